/* rtl/aip_top.sv */
// Analog input post-processing, status and AXI4-Lite register access
`default_nettype none
// Overview of operation
// - Disabled points are skipped entirely
// - Each point carries its own range
// - Results read as binary or BCD
// - Transfers start at pointer word
// - Scaling maps span onto limit pair
// - Filter slows response to abrupt changes
// - Averaging reports mean of samples
// - Peak hold reports largest value
// - High/low alarm flags on limits
// - Out-of-range flag per point
// - Parameters saved, reloaded at power-up
// - Run lamp steady; fault halts
// - Run lamp flashes past write endurance
// - Error lamp on fault or out-of-range
// - Range lamp on any out-of-range input
// - Four switch bits per input, ordered
// - Signed BCD saturates at 7999
// - Format per point, BCD default
// - Twelve-bit conversion codes
module aip_top
    import aip_pkg::*;
#(
    parameter int FLASH_CYC = FLASH_CYC_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter samples
    input wire logic smp_valid,
    input wire logic [3:0] smp_point,
    input wire logic [11:0] smp_code,
    input wire logic smp_oor,
    input wire logic diag_fault,
    // Switch pins
    input wire logic [63:0] range_sw,
    input wire logic [15:0] vi_sw,
    // Front end control
    output logic [15:0] scan_en,
    output logic [63:0] range_sel,
    output logic [15:0] vi_sel,
    // Parameter memory
    input wire logic [15:0] ee_rdata,
    input wire logic ee_ack,
    output logic [6:0] ee_addr,
    output logic [15:0] ee_wdata,
    output logic ee_we,
    output logic ee_re,
    // Indicators
    output logic led_run,
    output logic led_err,
    output logic led_range
);
    function automatic logic [6:0] pidx(input logic [6:0] base,
                                        input logic [3:0] pt);
        return base + {3'h0, pt};
    endfunction
    function automatic logic reg_hit(input logic [7:0] a);
        return a == A_CTRL || a == A_STAT || a == A_PTR || a == A_DATA;
    endfunction

    aip_state_type state_reg;
    logic [PRM_N-1:0][15:0] prm_reg;
    logic [NPT-1:0][15:0] res_reg, filt_reg, pk_reg;
    logic [NPT-1:0][19:0] acc_reg;
    logic [NPT-1:0][3:0] cnt_reg;
    logic [15:0] fhi_reg, flo_reg, oor_reg, ee_cnt_reg;
    logic [63:0] rsw_s1_reg;
    logic [15:0] vsw_s1_reg;
    logic [6:0] ptr_reg, cur_reg, ee_idx_reg, widx, ridx;
    logic [31:0] fl_cnt_reg;
    logic blink_reg;
    logic [15:0] cfg, x, v1, v2, v3, v4, f, map_word, wval;
    logic signed [16:0] diff, step;
    logic signed [19:0] avq;
    logic [19:0] acc_n;
    logic [3:0] cnt_n;
    logic [1:0] avn;
    logic take, avg_done, res_wr;
    logic wr_go, wr_fire, rd_go, rd_fire, dat_wr, dat_rd, ctrl_save;
    logic [31:0] rd_word;
    logic [15:0] res_sel;

    aip_num_if sc_n();
    aip_num_if bc_n();
    aip_scale u_scale (.n(sc_n.unit));
    aip_bcd u_bcd (.n(bc_n.unit));

    assign x = {4'h0, smp_code};
    assign sc_n.din = x;
    assign sc_n.lo = prm_reg[pidx(MAP_SLO, smp_point)];
    assign sc_n.hi = prm_reg[pidx(MAP_SHI, smp_point)];
    assign res_sel = res_reg[ridx[3:0]];
    assign bc_n.din = res_sel;
    assign bc_n.lo = '0;
    assign bc_n.hi = '0;

    always_comb begin
        cfg = prm_reg[pidx(MAP_CFG, smp_point)];
        f = filt_reg[smp_point];
        v1 = cfg[CFG_SCL] ? sc_n.dout : x;
        diff = $signed({v1[15], v1}) - $signed({f[15], f});
        step = diff >>> FILT_SH;
        v2 = cfg[CFG_FLT] ? f + step[15:0] : v1;
        avn = cfg[CFG_AVN +: 2];
        acc_n = acc_reg[smp_point] + {{4{v2[15]}}, v2};
        cnt_n = cnt_reg[smp_point] + 4'h1;
        avg_done = !cfg[CFG_AVG] || cnt_n == (4'h1 << avn);
        avq = $signed(acc_n) >>> avn;
        v3 = cfg[CFG_AVG] ? avq[15:0] : v2;
        v4 = (cfg[CFG_PK] && $signed(pk_reg[smp_point]) > $signed(v3)) ?
             pk_reg[smp_point] : v3;
        take = smp_valid && cfg[CFG_EN] && state_reg == ST_RUN;
        res_wr = take && avg_done;
    end

    // Sample processing state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_reg <= '0;
            acc_reg <= '0;
            cnt_reg <= '0;
            res_reg <= '0;
            fhi_reg <= '0;
            flo_reg <= '0;
            oor_reg <= '0;
            pk_reg <= {NPT{PK_RST}};
        end else begin
            for (int i = 0; i < NPT; i++) begin
                if (!prm_reg[pidx(MAP_CFG, 4'(i))][CFG_PK])
                    pk_reg[i] <= PK_RST;
                if (!prm_reg[pidx(MAP_CFG, 4'(i))][CFG_EN])
                    oor_reg[i] <= 1'b0;
            end
            if (take) begin
                filt_reg[smp_point] <= v2;
                oor_reg[smp_point] <= smp_oor;
                acc_reg[smp_point] <= avg_done ? '0 : acc_n;
                cnt_reg[smp_point] <= avg_done ? '0 : cnt_n;
            end
            if (res_wr) begin
                res_reg[smp_point] <= v4;
                if (cfg[CFG_PK])
                    pk_reg[smp_point] <= v4;
                fhi_reg[smp_point] <= $signed(v4) >
                    $signed(prm_reg[pidx(MAP_AHI, smp_point)]);
                flo_reg[smp_point] <= $signed(v4) <
                    $signed(prm_reg[pidx(MAP_ALO, smp_point)]);
            end
        end
    end

    // AXI handshakes
    assign wr_go = awvalid && wvalid && !awready && !bvalid;
    assign wr_fire = awready && awvalid && wvalid;
    assign rd_go = arvalid && !arready && !rvalid;
    assign rd_fire = arready && arvalid;
    assign dat_wr = wr_fire && awaddr == A_DATA;
    assign dat_rd = rd_fire && araddr == A_DATA;
    assign ctrl_save = wr_fire && awaddr == A_CTRL && wdata[CTRL_SAVE];
    assign widx = ptr_reg + cur_reg;
    assign ridx = ptr_reg + cur_reg + {6'h0, dat_wr};
    assign wval = {wstrb[1] ? wdata[15:8] : prm_reg[widx][15:8],
                   wstrb[0] ? wdata[7:0] : prm_reg[widx][7:0]};

    always_comb begin
        map_word = '0;
        if (ridx < MAP_RES)
            map_word = prm_reg[ridx];
        else if (ridx < MAP_FHI)
            map_word = prm_reg[pidx(MAP_CFG, ridx[3:0])][CFG_BIN] ?
                       res_sel : bc_n.dout;
        else if (ridx == MAP_FHI)
            map_word = fhi_reg;
        else if (ridx == MAP_FLO)
            map_word = flo_reg;
        else if (ridx == MAP_FOR)
            map_word = oor_reg;
        else if (ridx == MAP_VI)
            map_word = vi_sel;
        else if (ridx == MAP_EEC)
            map_word = ee_cnt_reg;
        unique case (araddr)
            A_STAT: rd_word = {ee_cnt_reg, 12'h000, state_reg};
            A_PTR: rd_word = {25'h0, ptr_reg};
            A_DATA: rd_word = {16'h0, map_word};
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= RESP_OK;
            rdata <= '0;
        end else begin
            awready <= wr_go;
            wready <= wr_go;
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= reg_hit(awaddr) ? RESP_OK : RESP_SLV;
            end else if (bready)
                bvalid <= 1'b0;
            arready <= rd_go;
            if (rd_fire) begin
                rvalid <= 1'b1;
                rresp <= reg_hit(araddr) ? RESP_OK : RESP_SLV;
                rdata <= rd_word;
            end else if (rready)
                rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_reg <= '0;
            cur_reg <= '0;
        end else if (wr_fire && awaddr == A_PTR) begin
            ptr_reg <= wdata[6:0];
            cur_reg <= '0;
        end else
            cur_reg <= cur_reg + {6'h0, dat_wr} + {6'h0, dat_rd};
    end

    // Parameter store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PRM_N; i++)
                prm_reg[i] <= prm_rst(7'(i));
        end else if (state_reg == ST_LOAD && ee_ack)
            prm_reg[ee_idx_reg] <= ee_rdata;
        else if (dat_wr && widx <= MAP_LAST)
            prm_reg[widx] <= wval;
    end

    // load at start-up, save on request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_LOAD;
            ee_idx_reg <= '0;
            ee_re <= 1'b0;
            ee_we <= 1'b0;
            ee_wdata <= '0;
            ee_cnt_reg <= '0;
        end else begin
            ee_wdata <= prm_reg[ee_idx_reg];
            if (diag_fault) begin
                state_reg <= ST_HALT;
                ee_re <= 1'b0;
                ee_we <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_LOAD, ST_SAVE: begin
                        ee_re <= state_reg == ST_LOAD && !ee_ack;
                        ee_we <= state_reg == ST_SAVE && !ee_ack;
                        if (ee_ack && ee_idx_reg == MAP_LAST) begin
                            ee_idx_reg <= '0;
                            state_reg <= ST_RUN;
                            if (state_reg == ST_SAVE && ~&ee_cnt_reg)
                                ee_cnt_reg <= ee_cnt_reg + 16'h0001;
                        end else if (ee_ack)
                            ee_idx_reg <= ee_idx_reg + 7'h01;
                    end
                    ST_RUN: if (ctrl_save) state_reg <= ST_SAVE;
                    ST_HALT: state_reg <= ST_HALT;
                    default: state_reg <= ST_HALT;
                endcase
            end
        end
    end
    assign ee_addr = ee_idx_reg;

    // Indicators and front end outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fl_cnt_reg <= '0;
            blink_reg <= 1'b0;
            led_run <= 1'b0;
            led_err <= 1'b0;
            led_range <= 1'b0;
            scan_en <= '0;
        end else begin
            fl_cnt_reg <= (fl_cnt_reg == 32'(FLASH_CYC - 1)) ? '0 :
                          fl_cnt_reg + 32'h1;
            if (fl_cnt_reg == 32'(FLASH_CYC - 1))
                blink_reg <= ~blink_reg;
            led_run <= state_reg != ST_HALT && !diag_fault &&
                       (ee_cnt_reg > EE_LIMIT ? blink_reg : 1'b1);
            led_err <= diag_fault || (|oor_reg) || state_reg == ST_HALT;
            led_range <= |oor_reg;
            for (int i = 0; i < NPT; i++)
                scan_en[i] <= prm_reg[pidx(MAP_CFG, 4'(i))][CFG_EN];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsw_s1_reg <= '0;
            range_sel <= '0;
            vsw_s1_reg <= '0;
            vi_sel <= '0;
        end else begin
            rsw_s1_reg <= range_sw;
            range_sel <= rsw_s1_reg;
            vsw_s1_reg <= vi_sw;
            vi_sel <= vsw_s1_reg;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    skip_disabled_a: assert property (smp_valid && !cfg[CFG_EN] |=>
        $stable(res_reg)) else $error("disabled point updated");
    ptr_start_a: assert property (wr_fire && awaddr == A_PTR |=>
        cur_reg == '0) else $error("cursor not restarted");
    bcd_sat_a: assert property (!res_sel[15] &&
        res_sel > {3'h0, BCD_MAX} |-> bc_n.dout == BCD_SAT)
        else $error("bcd not saturated");
    halt_dark_a: assert property (diag_fault |=>
        state_reg == ST_HALT ##1 !led_run) else $error("no halt");
    flash_off_a: assert property (state_reg == ST_RUN &&
        !diag_fault && ee_cnt_reg <= EE_LIMIT |=> led_run)
        else $error("run lamp not steady");
    err_lamp_a: assert property ((diag_fault || |oor_reg) |=>
        led_err) else $error("error lamp off");
    range_lamp_a: assert property (|oor_reg |=> led_range)
        else $error("range lamp off");
    alarm_hi_a: assert property (res_wr && $signed(v4) >
        $signed(prm_reg[pidx(MAP_AHI, smp_point)]) |=>
        fhi_reg[$past(smp_point)]) else $error("high alarm missing");
    save_done_c: cover property (state_reg == ST_SAVE ##1
        state_reg == ST_RUN);
    avg_result_c: cover property (res_wr && cfg[CFG_AVG]);
    halt_c: cover property (state_reg == ST_HALT);
endmodule
`default_nettype wire

/* shared/aip_pkg.sv */
// Constants and types for the analog input post-processing block
`default_nettype none
package aip_pkg;
    localparam int CLK_KHZ = 50000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_CYC_DEF = FLASH_HALF_MS * CLK_KHZ;
    localparam int NPT = 16;
    localparam int PRM_N = 80;
    // Memory-map word indices
    localparam logic [6:0] MAP_CFG = 7'h00;
    localparam logic [6:0] MAP_AHI = 7'h10;
    localparam logic [6:0] MAP_ALO = 7'h20;
    localparam logic [6:0] MAP_SLO = 7'h30;
    localparam logic [6:0] MAP_SHI = 7'h40;
    localparam logic [6:0] MAP_RES = 7'h50;
    localparam logic [6:0] MAP_FHI = 7'h60;
    localparam logic [6:0] MAP_FLO = 7'h61;
    localparam logic [6:0] MAP_FOR = 7'h62;
    localparam logic [6:0] MAP_VI = 7'h63;
    localparam logic [6:0] MAP_EEC = 7'h64;
    localparam logic [6:0] MAP_LAST = 7'h4f;
    // AXI byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_PTR = 8'h08;
    localparam logic [7:0] A_DATA = 8'h0c;
    localparam int CTRL_SAVE = 0;
    // Per-point configuration word fields
    localparam int CFG_EN = 0;
    localparam int CFG_BIN = 1;
    localparam int CFG_SCL = 2;
    localparam int CFG_FLT = 3;
    localparam int CFG_AVG = 4;
    localparam int CFG_PK = 5;
    localparam int CFG_AVN = 6;
    localparam logic [15:0] CFG_RST = 16'h0001;
    localparam logic [15:0] AHI_RST = 16'h7fff;
    localparam logic [15:0] ALO_RST = 16'h8000;
    localparam logic [15:0] SLO_RST = 16'h0000;
    localparam logic [15:0] SHI_RST = 16'h0fff;
    localparam logic [15:0] PK_RST = 16'h8000;
    localparam logic [15:0] EE_LIMIT = 16'd10000;
    localparam logic [15:0] BCD_SAT = 16'h7999;
    localparam logic [12:0] BCD_MAX = 13'd7999;
    localparam int FILT_SH = 2;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLV = 2'b10;
    typedef enum logic [3:0] {
        ST_LOAD = 4'b0001,
        ST_RUN = 4'b0010,
        ST_SAVE = 4'b0100,
        ST_HALT = 4'b1000
    } aip_state_type;
    function automatic logic [15:0] prm_rst(input logic [6:0] idx);
        if (idx < MAP_AHI) return CFG_RST;
        if (idx < MAP_ALO) return AHI_RST;
        if (idx < MAP_SLO) return ALO_RST;
        if (idx < MAP_SHI) return SLO_RST;
        return SHI_RST;
    endfunction
endpackage
`default_nettype wire

/* shared/aip_num_if.sv */
// Number conversion carrier between the top and its arithmetic units
`default_nettype none
interface aip_num_if;
    logic [15:0] din;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] dout;
    modport host(output din, output lo, output hi, input dout);
    modport unit(input din, input lo, input hi, output dout);
endinterface
`default_nettype wire

/* rtl/aip_scale.sv */
// Linear scaling of a 12-bit code onto a lower/upper limit pair
`default_nettype none
module aip_scale (
    aip_num_if.unit n
);
    logic signed [16:0] span;
    logic signed [29:0] prod;
    logic [12:0] dn;
    // Upper half rounds up so the top code lands on the upper limit
    assign dn = {1'b0, n.din[11:0]} + {12'h000, n.din[11]};
    assign span = $signed({n.hi[15], n.hi}) - $signed({n.lo[15], n.lo});
    assign prod = span * $signed({1'b0, dn});
    assign n.dout = n.lo + prod[27:12];
endmodule
`default_nettype wire

/* rtl/aip_bcd.sv */
// Signed BCD encoder, magnitude saturated, sign in bit 15
`default_nettype none
module aip_bcd
    import aip_pkg::*;
(
    aip_num_if.unit n
);
    logic [15:0] mag;
    logic [12:0] m;
    assign mag = n.din[15] ? 16'(-n.din) : n.din;
    assign m = (mag > {3'h0, BCD_MAX}) ? BCD_MAX : mag[12:0];
    assign n.dout = {n.din[15], 3'(m / 13'd1000),
                     4'((m / 13'd100) % 13'd10),
                     4'((m / 13'd10) % 13'd10), 4'(m % 13'd10)};
endmodule
`default_nettype wire

/* sim/aip_ee_model.sv */
// Behavioural parameter memory that answers the block's EEPROM requests
`default_nettype none
module aip_ee_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the block
    input wire logic [6:0] ee_addr,
    input wire logic [15:0] ee_wdata,
    input wire logic ee_we,
    input wire logic ee_re,
    // Slow answers when high
    input wire logic slow,
    // Answers
    output logic [15:0] ee_rdata,
    output logic ee_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:79];
    int cnt;
    // Contents kept across resets
    initial begin
        for (int i = 0; i < 80; i++) begin
            mem[i] = (i < 16) ? 16'h0001 : (i < 32) ? 16'h7fff :
                (i < 48) ? 16'h8000 : (i < 64) ? 16'h0000 : 16'h0fff;
        end
        mem[3] = 16'h0003;
        ee_rdata = 16'h0000;
        ee_ack = 1'b0;
        cnt = 0;
    end
    always @(posedge aclk) begin
        ee_ack <= 1'b0;
        if (!aresetn) begin
            cnt <= 0;
        end else if ((ee_re || ee_we) && !ee_ack) begin
            if (cnt >= (slow ? 5 : 0)) begin
                ee_ack <= 1'b1;
                cnt <= 0;
                if (ee_we) begin
                    mem[ee_addr] <= ee_wdata;
                end else begin
                    ee_rdata <= mem[ee_addr];
                end
            end else begin
                cnt <= cnt + 1;
            end
        end else begin
            // Data not valid outside an answer
            ee_rdata <= ~ee_rdata;
        end
    end
endmodule
`default_nettype wire

/* sim/tb_aip_top.sv */
// Register-level testbench of the analog input post-processing block
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_aip_top
    import aip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic smp_valid, smp_oor, diag_fault, ee_we, ee_re, ee_ack, slow;
    logic [3:0] smp_point;
    logic [11:0] smp_code;
    logic [63:0] range_sw, range_sel;
    logic [15:0] vi_sw, vi_sel, scan_en, ee_rdata, ee_wdata;
    logic [6:0] ee_addr;
    logic led_run, led_err, led_range;
    int errors = 0;
    int checks = 0;

    aip_top #(.FLASH_CYC(8)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .smp_valid(smp_valid), .smp_point(smp_point), .smp_code(smp_code),
        .smp_oor(smp_oor), .diag_fault(diag_fault), .range_sw(range_sw),
        .vi_sw(vi_sw), .scan_en(scan_en), .range_sel(range_sel),
        .vi_sel(vi_sel), .ee_rdata(ee_rdata), .ee_ack(ee_ack),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_we(ee_we),
        .ee_re(ee_re), .led_run(led_run), .led_err(led_err),
        .led_range(led_range)
    );
    aip_ee_model ee (
        .aclk(aclk), .aresetn(aresetn), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_we(ee_we), .ee_re(ee_re), .slow(slow),
        .ee_rdata(ee_rdata), .ee_ack(ee_ack)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] rs);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((aw || w) && n < 1000) begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1 && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        rs = bresp;
        if (n >= 1000) errors++;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 1000);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        d = rdata;
        rs = rresp;
        if (n >= 1000) errors++;
    endtask

    task automatic map_wr(input logic [6:0] i, input logic [15:0] d);
        logic [1:0] q;
        axi_wr(A_PTR, {25'h0, i}, q);
        axi_wr(A_DATA, {16'h0, d}, q);
    endtask

    task automatic map_chk(input logic [6:0] i, input logic [15:0] e);
        logic [1:0] q;
        axi_wr(A_PTR, {25'h0, i}, q);
        axi_rd(A_DATA, v, q);
        `CHK("map word", {16'h0, e}, v)
    endtask

    task automatic smp(input logic [3:0] p, input logic [11:0] c,
                       input logic o);
        smp_valid <= 1'b1;
        smp_point <= p;
        smp_code <= c;
        smp_oor <= o;
        @(posedge aclk);
        smp_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        do begin
            axi_rd(A_STAT, v, r);
            n++;
        end while (v[3:0] !== 4'h2 && n < 500);
        if (n >= 500) errors++;
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    initial begin
        repeat (60000) @(posedge aclk);
        errors++;
        stop_test();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {smp_valid, smp_point, smp_code, smp_oor, diag_fault} = 19'h0;
        range_sw = 64'hfedcba9876543210;
        vi_sw = 16'ha5c3;
        slow = 1'b0;
        aresetn = 1'b0;
        do_reset();
        axi_rd(A_STAT, v, r);
        `CHK("state load", 4'h1, v[3:0])
        wait_run();
        map_chk(MAP_CFG + 7'd3, 16'h0003);
        `CHK("run lamp", 1'b1, led_run)
        `CHK("range sel", range_sw, range_sel)
        `CHK("vi sel", vi_sw, vi_sel)
        map_chk(MAP_VI, 16'ha5c3);
        axi_rd(8'h10, v, r);
        `CHK("unmapped resp", RESP_SLV, r)
        `CHK("unmapped data", 32'h0, v)
        axi_wr(8'h20, 32'h1, r);
        `CHK("unmapped wresp", RESP_SLV, r)
        $display("test access done");
        map_wr(MAP_CFG + 7'd2, 16'h0003);
        smp(4'd2, 12'h123, 1'b0);
        map_wr(MAP_CFG + 7'd2, 16'h0000);
        @(posedge aclk);
        `CHK("scan enable", 2'b01, {scan_en[2], scan_en[0]})
        smp(4'd2, 12'h456, 1'b0);
        map_chk(MAP_RES + 7'd2, 16'h0291);
        map_wr(MAP_CFG + 7'd1, 16'h0003);
        smp(4'd0, 12'hfff, 1'b0);
        smp(4'd1, 12'hfff, 1'b0);
        map_chk(MAP_RES + 7'd0, 16'h4095);
        map_chk(MAP_RES + 7'd1, 16'h0fff);
        $display("test format done");
        map_wr(MAP_CFG + 7'd4, 16'h0005);
        map_wr(MAP_SLO + 7'd4, 16'hdcd8);
        map_wr(MAP_SHI + 7'd4, 16'h2328);
        map_wr(MAP_CFG + 7'd5, 16'h0007);
        map_wr(MAP_SLO + 7'd5, 16'hff9c);
        map_wr(MAP_SHI + 7'd5, 16'h0064);
        smp(4'd4, 12'h000, 1'b0);
        smp(4'd5, 12'hfff, 1'b0);
        map_chk(MAP_RES + 7'd4, 16'hf999);
        map_chk(MAP_RES + 7'd5, 16'h0064);
        smp(4'd4, 12'hfff, 1'b0);
        smp(4'd5, 12'h000, 1'b0);
        axi_wr(A_PTR, {25'h0, MAP_RES + 7'd4}, r);
        axi_rd(A_DATA, v, r);
        `CHK("cursor first", 32'h7999, v)
        axi_rd(A_DATA, v, r);
        `CHK("cursor next", 32'hff9c, v)
        $display("test scaling done");
        map_wr(MAP_CFG + 7'd6, 16'h000b);
        smp(4'd6, 12'h800, 1'b0);
        map_chk(MAP_RES + 7'd6, 16'h0200);
        smp(4'd6, 12'h800, 1'b0);
        map_chk(MAP_RES + 7'd6, 16'h0380);
        map_wr(MAP_CFG + 7'd7, 16'h0053);
        smp(4'd7, 12'd100, 1'b0);
        smp(4'd7, 12'd300, 1'b0);
        map_chk(MAP_RES + 7'd7, 16'h00c8);
        map_wr(MAP_CFG + 7'd8, 16'h0023);
        smp(4'd8, 12'd500, 1'b0);
        smp(4'd8, 12'd200, 1'b0);
        map_chk(MAP_RES + 7'd8, 16'h01f4);
        map_wr(MAP_CFG + 7'd8, 16'h0003);
        smp(4'd8, 12'd200, 1'b0);
        map_chk(MAP_RES + 7'd8, 16'h00c8);
        $display("test processing done");
        map_wr(MAP_CFG + 7'd9, 16'h0003);
        map_wr(MAP_AHI + 7'd9, 16'h03e8);
        map_wr(MAP_ALO + 7'd9, 16'h0064);
        smp(4'd9, 12'd2000, 1'b0);
        map_chk(MAP_FHI, 16'h0200);
        smp(4'd9, 12'd50, 1'b0);
        map_chk(MAP_FHI, 16'h0000);
        map_chk(MAP_FLO, 16'h0200);
        smp(4'd9, 12'd500, 1'b0);
        map_chk(MAP_FLO, 16'h0000);
        smp(4'd10, 12'h000, 1'b1);
        map_chk(MAP_FOR, 16'h0400);
        `CHK("range lamp on", 1'b1, led_range)
        `CHK("error lamp on", 1'b1, led_err)
        smp(4'd10, 12'h000, 1'b0);
        map_chk(MAP_FOR, 16'h0000);
        `CHK("range lamp off", 1'b0, led_range)
        `CHK("error lamp off", 1'b0, led_err)
        $display("test alarms done");
        map_wr(MAP_CFG + 7'd3, 16'h0023);
        slow <= 1'b1;
        axi_wr(A_CTRL, 32'h1, r);
        wait_run();
        `CHK("save count", 16'h0001, v[31:16])
        map_chk(MAP_EEC, 16'h0001);
        do_reset();
        wait_run();
        map_chk(MAP_CFG + 7'd3, 16'h0023);
        $display("test save done");
        diag_fault <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(A_STAT, v, r);
        `CHK("halt state", 4'h8, v[3:0])
        `CHK("run lamp off", 1'b0, led_run)
        `CHK("fault lamp", 1'b1, led_err)
        $display("test fault done");
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
